// file: logic/apmc_power_ctrl.sv
// power-mode and conversion-start control for a 12-bit sampling converter
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - bipolar results are two's complement, one step equals span over 4096
// - sleep input ignored while power-up calibration runs
// - two-bit power-mode field, resets to normal 00
// - mode 01: full power-down after current work and every conversion
// - mode 10: full power-down immediately once calibrated, aborting any conversion
// - mode 11: partial power-down after each conversion
// - partial power-down keeps the reference powered
// - start pin falling edge wakes device in modes 01 and 11
// - control-register start bit also begins a conversion
// - write with both msbs zero acts as all-zeros write
// - start pin rising edge holds the sample and converts
// - start bit clears when busy falls after a conversion, unless a start write lands in that cycle
module apmc_power_ctrl
    import apmc_pkg::*;
#(
    parameter int SETTLE_CYC = APMC_SETTLE_CYC,
    parameter int CAL_CYC    = APMC_CAL_CYC,
    parameter int CONV_CYC   = APMC_CONV_CYC
) (
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    input  wire logic                     conversion_start_n,
    input  wire logic                     sleepReq_n,
    input  wire logic                     ctlWrite,
    input  wire logic [APMC_CTL_W-1:0]    ctlData,
    input  wire logic [APMC_RES_BITS-1:0] rawResult,
    output logic                          busy,
    output logic                          trackHold,
    output logic                          fullPowerDown,
    output logic                          partialPowerDown,
    output logic                          refPowered,
    output logic                          calibrated,
    output logic [1:0]                    powerMode,
    output logic                          startBit,
    output logic                          resultValid,
    output logic [APMC_RES_BITS-1:0]      result
);
    // ************************************************************
    // state record
    // ************************************************************
    typedef struct packed {
        apmc_state_e             st;
        logic [1:0]              mode;
        logic                    startBit;
        logic                    bipolar;
        logic                    cvstPrev;
        logic                    wokeByPin;
        logic                    calDone;
        logic                    skipCal;
        logic                    hold;
        logic                    busy;
        logic                    sleepPd;
        logic                    fullPd;
        logic                    partPd;
        logic                    refOn;
        logic [APMC_CNT_W-1:0]   cnt;
        logic                    resValid;
        logic [APMC_RES_BITS-1:0] res;
    } apmc_state_s;

    apmc_state_s q_r;
    apmc_state_s q_nxt;
    logic [APMC_RES_BITS-1:0] fmtCode;

    // ************************************************************
    // helpers
    // ************************************************************
    // modes that power down after a conversion finishes
    function automatic logic apmc_pd_after(input logic [1:0] m);
        return (m == APMC_MODE_FULLAFT) || (m == APMC_MODE_PARTAFT);
    endfunction : apmc_pd_after

    // state entered once a conversion or calibration ends
    function automatic apmc_state_e apmc_after_st(input logic [1:0] m);
        case (m)
            APMC_MODE_FULLAFT: return APMC_ST_FULLPD;
            APMC_MODE_PARTAFT: return APMC_ST_PARTPD;
            APMC_MODE_FULLNOW: return APMC_ST_FULLPD;
            default:           return APMC_ST_IDLE;
        endcase
    endfunction : apmc_after_st

    apmc_code_fmt #(
        .WIDTH (APMC_RES_BITS)
    ) u_fmt (
        .rawCode (rawResult),
        .bipolar (q_r.bipolar),
        .outCode (fmtCode)
    );

    // ************************************************************
    // next-state logic
    // ************************************************************
    always_comb begin
        logic fallEdge;
        logic riseEdge;
        logic startReq;
        logic wrNorm;
        logic endWork;
        fallEdge = q_r.cvstPrev & ~conversion_start_n;
        riseEdge = ~q_r.cvstPrev & conversion_start_n;
        wrNorm   = ctlWrite & (ctlData[APMC_CTL_MODE_HI] |
                               ctlData[APMC_CTL_MODE_LO]);
        endWork  = 1'b0;
        startReq = riseEdge | q_r.startBit;
        q_nxt          = q_r;
        q_nxt.cvstPrev = conversion_start_n;
        q_nxt.resValid = 1'b0;
        // control write; msbs both zero means an all-zeros write
        if (ctlWrite) begin
            if (wrNorm) begin
                q_nxt.mode = {ctlData[APMC_CTL_MODE_HI],
                              ctlData[APMC_CTL_MODE_LO]};
                q_nxt.bipolar = ctlData[APMC_CTL_BIPOLAR];
                if (ctlData[APMC_CTL_START]) begin
                    q_nxt.startBit = 1'b1;
                end
            end else begin
                q_nxt.mode = APMC_MODE_NORMAL;
            end
            // a write before calibration starts disables it
            if (!q_r.calDone && q_r.st != APMC_ST_CAL) begin
                q_nxt.skipCal = 1'b1;
            end
        end
        // sleep pin only counts once calibration has finished
        q_nxt.sleepPd = q_r.calDone & ~sleepReq_n;
        if (q_r.cnt != '0) begin
            q_nxt.cnt = q_r.cnt - APMC_CNT_W'(1);
        end
        case (q_r.st)
            APMC_ST_UNCAL: begin
                if (riseEdge) begin
                    q_nxt.st   = APMC_ST_SETTLE;
                    q_nxt.busy = 1'b1;
                    q_nxt.cnt  = APMC_CNT_W'(SETTLE_CYC);
                end
            end
            APMC_ST_SETTLE: begin
                // start pulses are gated by busy here
                if (q_r.cnt == APMC_CNT_W'(1)) begin
                    q_nxt.busy = 1'b0;
                    q_nxt.st   = q_nxt.skipCal ? APMC_ST_IDLE
                                               : APMC_ST_CAL;
                    q_nxt.calDone = q_nxt.skipCal;
                end
            end
            APMC_ST_CAL: begin
                if (q_r.busy && q_r.cnt == APMC_CNT_W'(1)) begin
                    q_nxt.busy    = 1'b0;
                    q_nxt.calDone = 1'b1;
                    endWork       = 1'b1;
                end else if (!q_r.busy && riseEdge) begin
                    q_nxt.busy = 1'b1;
                    q_nxt.cnt  = APMC_CNT_W'(CAL_CYC);
                end
            end
            APMC_ST_IDLE: begin
                if (startReq) begin
                    q_nxt.st   = APMC_ST_CONVERT;
                    q_nxt.hold = 1'b1;
                    q_nxt.busy = 1'b1;
                    q_nxt.cnt  = APMC_CNT_W'(CONV_CYC);
                end
            end
            APMC_ST_CONVERT: begin
                if (q_r.cnt == APMC_CNT_W'(1)) begin
                    q_nxt.busy     = 1'b0;
                    q_nxt.hold     = 1'b0;
                    // a start write in the same cycle wins over the clear
                    if (!(wrNorm && ctlData[APMC_CTL_START])) begin
                        q_nxt.startBit = 1'b0;
                    end
                    q_nxt.res      = fmtCode;
                    q_nxt.resValid = 1'b1;
                    q_nxt.wokeByPin = 1'b0;
                    endWork        = 1'b1;
                end
            end
            APMC_ST_FULLPD, APMC_ST_PARTPD: begin
                // falling start edge wakes; the mode field stays put
                if (fallEdge && apmc_pd_after(q_r.mode)) begin
                    q_nxt.st        = APMC_ST_IDLE;
                    q_nxt.wokeByPin = 1'b1;
                end else if (wrNorm && !apmc_pd_after(q_nxt.mode)
                             && q_nxt.mode != APMC_MODE_FULLNOW) begin
                    q_nxt.st = APMC_ST_IDLE;
                end else if (!wrNorm && ctlWrite) begin
                    q_nxt.st = APMC_ST_IDLE;
                end
            end
            default: q_nxt.st = APMC_ST_UNCAL;
        endcase
        // finished work drops into the state the mode selects: full or partial power-down, or idle in mode 00
        if (endWork) begin
            q_nxt.st = apmc_after_st(q_nxt.mode);
        end
        // immediate full power-down aborts conversion, not calibration
        if (q_nxt.mode == APMC_MODE_FULLNOW && q_r.calDone
            && q_nxt.st != APMC_ST_FULLPD) begin
            q_nxt.st       = APMC_ST_FULLPD;
            q_nxt.busy     = 1'b0;
            q_nxt.hold     = 1'b0;
            q_nxt.startBit = 1'b0;
            q_nxt.resValid = 1'b0;
            q_nxt.cnt      = '0;
        end
        // mode 01 from idle also powers down, idle means no work
        if (q_nxt.st == APMC_ST_IDLE && !q_nxt.wokeByPin
            && q_nxt.mode == APMC_MODE_FULLAFT && q_r.calDone
            && !startReq && !q_nxt.startBit) begin
            q_nxt.st = APMC_ST_FULLPD;
        end
        // power outputs registered so every port leaves a flip-flop
        q_nxt.fullPd = (q_nxt.st == APMC_ST_FULLPD) | q_nxt.sleepPd;
        q_nxt.partPd = (q_nxt.st == APMC_ST_PARTPD);
        // reference stays up in partial power-down
        q_nxt.refOn  = (q_nxt.st != APMC_ST_FULLPD) & ~q_nxt.sleepPd;
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q_r          <= '0;
            q_r.st       <= APMC_ST_UNCAL;
            q_r.mode     <= APMC_MODE_RESET;
            q_r.cvstPrev <= 1'b1;
            q_r.refOn    <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end

    // outputs straight from the state record
    assign busy             = q_r.busy;
    assign trackHold        = q_r.hold;
    assign fullPowerDown    = q_r.fullPd;
    assign partialPowerDown = q_r.partPd;
    assign refPowered       = q_r.refOn;
    assign calibrated       = q_r.calDone;
    assign powerMode        = q_r.mode;
    assign startBit         = q_r.startBit;
    assign resultValid      = q_r.resValid;
    assign result           = q_r.res;
endmodule : apmc_power_ctrl
`default_nettype wire

// file: logic/apmc_pkg.sv
// package of constants and types for the converter power-mode control block
package apmc_pkg;
    // ************************************************************
    // power-mode field encodings
    // ************************************************************
    typedef enum logic [1:0] {
        APMC_MODE_NORMAL  = 2'b00,
        APMC_MODE_FULLAFT = 2'b01,
        APMC_MODE_FULLNOW = 2'b10,
        APMC_MODE_PARTAFT = 2'b11
    } apmc_mode_e;

    // ************************************************************
    // sequencer states
    // ************************************************************
    typedef enum logic [2:0] {
        APMC_ST_UNCAL   = 3'b000,
        APMC_ST_SETTLE  = 3'b001,
        APMC_ST_IDLE    = 3'b010,
        APMC_ST_CONVERT = 3'b011,
        APMC_ST_CAL     = 3'b100,
        APMC_ST_FULLPD  = 3'b101,
        APMC_ST_PARTPD  = 3'b110
    } apmc_state_e;

    localparam int         APMC_RES_BITS    = 12;
    localparam int         APMC_CODE_STEPS  = 4096;
    localparam logic [1:0] APMC_MODE_RESET  = 2'b00;
    // control word layout: two msbs are the all-zeros qualifier
    localparam int         APMC_CTL_W       = 12;
    localparam int         APMC_CTL_MODE_HI = 11;
    localparam int         APMC_CTL_MODE_LO = 10;
    localparam int         APMC_CTL_START   = 9;
    localparam int         APMC_CTL_BIPOLAR = 8;
    localparam int         APMC_CLK_MHZ     = 50;
    // auto-calibration timeouts and conversion length
    localparam int         APMC_SETTLE_US   = 32000;
    localparam int         APMC_CAL_US      = 32000;
    localparam int         APMC_CONV_CYC    = 17;
    localparam int         APMC_SETTLE_CYC  = APMC_SETTLE_US * APMC_CLK_MHZ;
    localparam int         APMC_CAL_CYC     = APMC_CAL_US * APMC_CLK_MHZ;
    localparam int         APMC_CNT_W       = 32;
endpackage : apmc_pkg

// file: logic/apmc_code_fmt.sv
// output code formatter: straight binary or two's complement
`timescale 1ns/1ps
`default_nettype none
module apmc_code_fmt
    import apmc_pkg::*;
#(
    parameter int WIDTH = APMC_RES_BITS
) (
    input  wire logic [WIDTH-1:0] rawCode,
    input  wire logic             bipolar,
    output logic      [WIDTH-1:0] outCode
);
    // bipolar: offset binary to two's complement by msb inversion
    always_comb begin
        outCode = bipolar ? {~rawCode[WIDTH-1], rawCode[WIDTH-2:0]}
                          : rawCode;
    end
endmodule : apmc_code_fmt
`default_nettype wire

// file: verification/apmc_power_ctrl_monitor.sv
// assertion checker for the converter power-mode control block
`timescale 1ns/1ps
`default_nettype none
module apmc_power_ctrl_monitor
    import apmc_pkg::*;
(
    input wire logic                  clk_sys,
    input wire logic                  rst,
    input wire logic                  conversion_start_n,
    input wire logic                  sleepReq_n,
    input wire logic                  ctlWrite,
    input wire logic [APMC_CTL_W-1:0] ctlData,
    input wire logic                  busy,
    input wire logic                  trackHold,
    input wire logic                  fullPowerDown,
    input wire logic                  partialPowerDown,
    input wire logic                  refPowered,
    input wire logic                  calibrated,
    input wire logic [1:0]            powerMode,
    input wire logic                  startBit,
    input wire logic                  resultValid
);
    // ************************************************************
    // power-mode and conversion relations, one clock domain
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_modeReset; $past(rst) |-> powerMode == 2'b00; endproperty
    a_modeReset: assert property (p_modeReset)
        else $error("mode not normal after reset");
    property p_fullAfter;
        $fell(busy) && powerMode == 2'b01 |-> ##[0:2] fullPowerDown;
    endproperty
    a_fullAfter: assert property (p_fullAfter)
        else $error("no full power-down after conversion");
    property p_fullNow;
        ctlWrite && ctlData[11:10] == 2'b10 && calibrated
            |-> ##[1:3] fullPowerDown && !busy;
    endproperty
    a_fullNow: assert property (p_fullNow)
        else $error("mode 10 did not power down at once");
    property p_partAfter;
        $fell(busy) && powerMode == 2'b11 |-> ##[0:2] partialPowerDown;
    endproperty
    a_partAfter: assert property (p_partAfter)
        else $error("no partial power-down after conversion");
    property p_partRef;
        partialPowerDown |-> refPowered && !fullPowerDown;
    endproperty
    a_partRef: assert property (p_partRef)
        else $error("reference off in partial power-down");
    property p_wake;
        (fullPowerDown || partialPowerDown) && powerMode[0]
            && $fell(conversion_start_n)
            |-> ##[1:3] !(fullPowerDown || partialPowerDown);
    endproperty
    a_wake: assert property (p_wake)
        else $error("start pin fall did not wake");
    property p_sleepMask;
        !calibrated && !sleepReq_n && powerMode == 2'b00 |-> !fullPowerDown;
    endproperty
    a_sleepMask: assert property (p_sleepMask)
        else $error("sleep honoured before calibration");
    // a start write landing on the busy fall legally re-arms the bit
    property p_startClr;
        $fell(busy) && !($past(ctlWrite) && $past(ctlData[9]))
            |-> ##[0:1] !startBit;
    endproperty
    a_startClr: assert property (p_startClr)
        else $error("start bit kept after busy fell");
    property p_resBusy; resultValid |-> $fell(busy) && !trackHold; endproperty
    a_resBusy: assert property (p_resBusy)
        else $error("result not at end of busy");
    property p_modeKeep;
        !$past(ctlWrite) && !$past(ctlWrite, 2) |-> $stable(powerMode);
    endproperty
    a_modeKeep: assert property (p_modeKeep)
        else $error("mode changed without a write");
endmodule : apmc_power_ctrl_monitor
`default_nettype wire

// file: verification/apmc_host_model.sv
// host processor model driving the start pin and control writes
`timescale 1ns/1ps
`default_nettype none
module apmc_host_model
    import apmc_pkg::*;
(
    input  wire logic                  clk_sys,
    output logic                       conversion_start_n,
    output logic                       ctlWrite,
    output logic [APMC_CTL_W-1:0]      ctlData
);
    // ************************************************************
    // pin and bus idle state
    // ************************************************************
    initial begin
        conversion_start_n = 1'b1;
        ctlWrite = 1'b0;
        ctlData = 12'h000;
    end
    // low pulse; a long low time stands in for the wake delay
    task automatic pulse(input int lowCyc);
        @(negedge clk_sys);
        conversion_start_n = 1'b0;
        repeat (lowCyc) @(negedge clk_sys);
        conversion_start_n = 1'b1;
    endtask : pulse
    // released data is inverted so a stale word never looks valid
    task automatic write(input logic [APMC_CTL_W-1:0] w);
        @(negedge clk_sys);
        ctlWrite = 1'b1;
        ctlData = w;
        @(negedge clk_sys);
        ctlWrite = 1'b0;
        ctlData = ~w;
    endtask : write
endmodule : apmc_host_model
`default_nettype wire

// file: verification/apmc_power_ctrl_bench.sv
// self-checking bench for the converter power-mode control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checksDone++; if ((g) !== (e)) begin \
    miscompares++; $display("Error %s expected %h seen %h", nm, e, g); end end
module apmc_power_ctrl_bench
    import apmc_pkg::*;
;
    localparam int SETTLE = 20;
    localparam int CAL    = 20;
    logic        clk_sys    = 1'b0;
    logic        rst        = 1'b1;
    logic        sleepReq_n;
    logic [11:0] rawResult;
    logic [11:0] ctlData, result;
    logic [1:0]  powerMode;
    logic        conversion_start_n, ctlWrite, busy, trackHold, startBit;
    logic        fullPowerDown, partialPowerDown, refPowered, calibrated;
    logic        resultValid;
    int          miscompares = 0;
    int          checksDone  = 0;
    // ************************************************************
    // clock, reset, host and device
    // ************************************************************
    always #10 clk_sys = ~clk_sys;
    apmc_host_model host (.clk_sys(clk_sys), .ctlData(ctlData),
        .conversion_start_n(conversion_start_n), .ctlWrite(ctlWrite));
    apmc_power_ctrl #(.SETTLE_CYC(SETTLE), .CAL_CYC(CAL),
        .CONV_CYC(APMC_CONV_CYC)) DUT (.clk_sys(clk_sys), .rst(rst),
        .conversion_start_n(conversion_start_n), .sleepReq_n(sleepReq_n),
        .ctlWrite(ctlWrite), .ctlData(ctlData), .rawResult(rawResult),
        .busy(busy), .trackHold(trackHold), .fullPowerDown(fullPowerDown),
        .partialPowerDown(partialPowerDown), .refPowered(refPowered),
        .calibrated(calibrated), .powerMode(powerMode), .startBit(startBit),
        .resultValid(resultValid), .result(result));
    // wait for busy, then count the cycles it stands high
    task automatic busyRun(output int n);
        int w;
        w = 0;
        n = 0;
        while (busy !== 1'b1 && w < 50) begin
            @(negedge clk_sys);
            w++;
        end
        while (busy === 1'b1 && n < 300) begin
            @(negedge clk_sys);
            n++;
        end
    endtask : busyRun
    task automatic conv(input logic [11:0] raw, input logic [11:0] exp);
        int n;
        rawResult = raw;
        busyRun(n);
        `CHK("convLen", APMC_CONV_CYC, n)
        `CHK("resultValid", 1'b1, resultValid)
        `CHK("result", exp, result)
    endtask : conv
    // sleep is held low from the start until after calibration, as a board may do
    task automatic t_powerup();
        int n;
        host.pulse(2);
        busyRun(n);
        `CHK("settleLen", SETTLE, n)
        `CHK("sleepMasked", 1'b0, fullPowerDown)
        host.pulse(2);
        busyRun(n);
        `CHK("calLen", CAL, n)
        `CHK("calibrated", 1'b1, calibrated)
        `CHK("modeReset", 2'b00, powerMode)
        repeat (2) @(negedge clk_sys);
        `CHK("sleepOn", 1'b1, fullPowerDown)
        sleepReq_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        `CHK("sleepOff", 1'b0, fullPowerDown)
        host.pulse(2);
        conv(12'h800, 12'h800);
        $display("test powerup done");
    endtask : t_powerup
    task automatic t_partial();
        host.write(12'hf00);
        conv(12'h000, 12'h800);
        @(negedge clk_sys);
        `CHK("partPd", 1'b1, partialPowerDown)
        `CHK("refOn", 1'b1, refPowered)
        `CHK("startClr", 1'b0, startBit)
        host.pulse(15);
        conv(12'hfff, 12'h7ff);
        @(negedge clk_sys);
        `CHK("modeKept", 2'b11, powerMode)
        `CHK("partAgain", 1'b1, partialPowerDown)
        $display("test partial done");
    endtask : t_partial
    // low bits are all set, yet the write must act as all zeros
    task automatic t_fullModes();
        host.write(12'h3ff);
        repeat (3) @(negedge clk_sys);
        `CHK("zeroMode", 2'b00, powerMode)
        `CHK("zeroStart", 1'b0, startBit)
        `CHK("zeroBusy", 1'b0, busy)
        `CHK("zeroWake", 1'b0, partialPowerDown)
        host.write(12'h600);
        conv(12'h123, 12'h123);
        @(negedge clk_sys);
        `CHK("fullPd", 1'b1, fullPowerDown)
        `CHK("refOff", 1'b0, refPowered)
        host.pulse(15);
        conv(12'h456, 12'h456);
        @(negedge clk_sys);
        `CHK("fullAgain", 1'b1, fullPowerDown)
        host.write(12'h000);
        host.pulse(2);
        repeat (4) @(negedge clk_sys);
        `CHK("midConv", 1'b1, busy)
        host.write(12'h800);
        repeat (3) @(negedge clk_sys);
        `CHK("fullNow", 1'b1, fullPowerDown)
        `CHK("aborted", 1'b0, busy)
        $display("test fullModes done");
    endtask : t_fullModes
    task automatic summarize();
        $display("checks %0d mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize
    // main sequence
    initial begin
        sleepReq_n = 1'b0;
        rawResult  = 12'h000;
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        t_powerup();
        t_partial();
        t_fullModes();
        summarize();
    end
    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (3000) @(posedge clk_sys);
        miscompares++;
        summarize();
    end
endmodule : apmc_power_ctrl_bench
bind apmc_power_ctrl apmc_power_ctrl_monitor u_mon (.clk_sys(clk_sys),
    .rst(rst), .conversion_start_n(conversion_start_n),
    .sleepReq_n(sleepReq_n), .ctlWrite(ctlWrite), .ctlData(ctlData),
    .busy(busy), .trackHold(trackHold), .fullPowerDown(fullPowerDown),
    .partialPowerDown(partialPowerDown), .refPowered(refPowered),
    .calibrated(calibrated), .powerMode(powerMode), .startBit(startBit),
    .resultValid(resultValid));
`default_nettype wire
